// file: supply_defines.svh
`ifndef SUPPLY_DEFINES_SVH
`define SUPPLY_DEFINES_SVH
`define SYNC_STAGES 3
`define HARD_RESET_NS 1000
`define CLK_PERIOD_NS 20
`define HARD_RESET_CYCLES ((`HARD_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HARD_RESET_CNT_W 6
`define MRST_POL_RESET 1'b0
`endif

// file: supply_pkg.sv
package supply_pkg;
   typedef enum logic [1:0] {src_none, src_main, src_vbus} supply_src_type;
endpackage

// file: pin_sync.sv
`timescale 1ns/1ns
`include "supply_defines.svh"
module pin_sync (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic pin_in,
   output logic level_out
);
   typedef struct packed {
      logic [`SYNC_STAGES-1:0] stage;
      logic level;
   } sync_state_type;
   sync_state_type st_r;
   sync_state_type st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.stage = {st_r.stage[`SYNC_STAGES-2:0], pin_in};
      // change accepted once stages two and three agree
      if (st_r.stage[`SYNC_STAGES-1] == st_r.stage[`SYNC_STAGES-2]) begin
         st_nxt.level = st_r.stage[`SYNC_STAGES-1];
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign level_out = st_r.level;
endmodule

// file: supply_select_reset_supervisor.sv
`timescale 1ns/1ns
`include "supply_defines.svh"
// Function
// - both good: run from main supply
// - only vbus good: run from vbus
// - main returns: switch back without reset
// - main lost while both present: hard reset
// - flag dead battery when main absent
// - hold domain inactive until por good
// - supervise aux output with programmable threshold
// - firmware condition enables aux output switch
// - aux undervoltage drives reset output low
// - asserted manual reset drives reset low
// - manual reset active high, configurable low
// - pulldown aux output while switch off
module supply_select_reset_supervisor (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic main_good_in,
   input wire logic main_below_2v85_in,
   input wire logic vbus_good_in,
   input wire logic por_main_good_in,
   input wire logic por_vbus_good_in,
   input wire logic por_rail_good_in,
   input wire logic aux_uv_in,
   input wire logic manual_reset_in,
   input wire logic mrst_active_low_cfg,
   input wire logic aux_switch_request,
   input wire logic aux_switch_need_main,
   input wire logic [3:0] aux_uv_threshold_cfg,
   output supply_pkg::supply_src_type supply_src,
   output logic sel_main_supply,
   output logic sel_vbus_supply,
   output logic hard_reset_req,
   output logic dead_battery,
   output logic main_domain_enable,
   output logic vbus_domain_enable,
   output logic internal_3v3_rail_enable,
   output logic [3:0] aux_uv_threshold,
   output logic aux_out_switch,
   output logic aux_out_pulldown,
   output logic reset_out_n
);
   import supply_pkg::*;
   localparam int unsigned HR_CYCLES = `HARD_RESET_CYCLES;
   localparam int unsigned NSYNC = 8;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn;
   assign raw_in = {manual_reset_in, aux_uv_in, por_rail_good_in, por_vbus_good_in, por_main_good_in,
                    vbus_good_in, main_below_2v85_in, main_good_in};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         pin_sync u_sync (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .pin_in(raw_in[gi]),
            .level_out(syn[gi])
         );
      end
   endgenerate
   logic main_ok, below, vbus_ok, por_m, por_v, por_r, aux_uv, mrst_lvl;
   assign main_ok = syn[0];
   assign below = syn[1];
   assign vbus_ok = syn[2];
   assign por_m = syn[3];
   assign por_v = syn[4];
   assign por_r = syn[5];
   assign aux_uv = syn[6];
   assign mrst_lvl = syn[7];
   typedef struct packed {
      supply_src_type src;
      logic both_seen;
      logic hr;
      logic [`HARD_RESET_CNT_W-1:0] hr_cnt;
      logic dead;
      logic sw;
      logic rst_n;
      logic [3:0] thr;
      logic mpol;
      logic cfg_taken;
   } top_state_type;
   top_state_type st_r;
   top_state_type st_nxt;

   // one-cycle event: both seen good, now main gone and below threshold
   logic main_lost;
   assign main_lost = st_r.both_seen && vbus_ok && !main_ok && below;
   function automatic logic mrst_asserted(input logic lvl, input logic pol_low);
      mrst_asserted = pol_low ? ~lvl : lvl;
   endfunction
   always_comb begin
      st_nxt = st_r;
      // polarity strap caught once after reset release
      if (!st_r.cfg_taken) begin
         st_nxt.mpol = mrst_active_low_cfg;
         st_nxt.cfg_taken = 1'b1;
      end
      if (main_ok && por_m) begin
         st_nxt.src = src_main;
      end else if (vbus_ok && por_v) begin
         st_nxt.src = src_vbus;
      end else begin
         st_nxt.src = src_none;
      end
      st_nxt.both_seen = main_ok && vbus_ok;
      if (st_r.hr_cnt != '0) begin
         st_nxt.hr_cnt = st_r.hr_cnt - 1'b1;
      end else begin
         st_nxt.hr = 1'b0;
      end
      if (main_lost) begin
         st_nxt.hr = 1'b1;
         st_nxt.hr_cnt = `HARD_RESET_CNT_W'(HR_CYCLES);
      end
      st_nxt.dead = ~main_ok;
      st_nxt.thr = aux_uv_threshold_cfg;
      st_nxt.sw = aux_switch_request && por_m && (main_ok || !aux_switch_need_main);
      st_nxt.rst_n = ~aux_uv && ~mrst_asserted(mrst_lvl, st_r.mpol);
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
         st_r.src <= src_none;
         st_r.mpol <= `MRST_POL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign supply_src = st_r.src;
   assign sel_main_supply = (st_r.src == src_main);
   assign sel_vbus_supply = (st_r.src == src_vbus);
   assign hard_reset_req = st_r.hr;
   assign dead_battery = st_r.dead;
   assign main_domain_enable = por_m;
   assign vbus_domain_enable = por_v;
   assign internal_3v3_rail_enable = por_r && (st_r.src != src_none);
   assign aux_uv_threshold = st_r.thr;
   assign aux_out_switch = st_r.sw;
   assign aux_out_pulldown = ~st_r.sw;
   assign reset_out_n = st_r.rst_n;

   // supply source selection
   chk_main_priority: assert property (@(posedge sys_clk) disable iff (!resetn)
      (main_ok && por_m) |=> st_r.src == src_main)
      else $error("main not selected");
   chk_vbus_fallback: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!main_ok && vbus_ok && por_v) |=> st_r.src == src_vbus)
      else $error("vbus not selected");
   chk_src_none: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!(main_ok && por_m) && !(vbus_ok && por_v)) |=> st_r.src == src_none)
      else $error("source kept without good supply");
   chk_switch_no_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st_r.src == src_vbus && main_ok && !st_r.both_seen) |=> !$rose(st_r.hr))
      else $error("reset on return");

   // hard reset: loss of main while both present, then a counted pulse
   sequence main_lost_s;
      st_r.both_seen && vbus_ok && !main_ok && below;
   endsequence
   sequence hr_start_s;
      $rose(st_r.hr);
   endsequence
   chk_hard_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      main_lost_s |=> st_r.hr [*2])
      else $error("hard reset missing");
   chk_hr_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
      hr_start_s |-> $past(main_lost))
      else $error("hard reset without supply loss");
   chk_hr_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      hr_start_s |-> st_r.hr_cnt == `HARD_RESET_CNT_W'(HR_CYCLES))
      else $error("hard reset count not loaded");
   chk_hr_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st_r.hr && st_r.hr_cnt != '0) |=> st_r.hr)
      else $error("hard reset ended early");
   chk_hr_end: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st_r.hr && st_r.hr_cnt == '0 && !main_lost) |=> !st_r.hr)
      else $error("hard reset too long");

   chk_dead_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> dead_battery == !$past(main_ok))
      else $error("dead flag wrong");
   chk_dead_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
      main_ok |=> !dead_battery)
      else $error("dead flag stuck");

   chk_rail_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      !por_r |-> !internal_3v3_rail_enable)
      else $error("rail on early");
   chk_switch_por: assert property (@(posedge sys_clk) disable iff (!resetn)
      !por_m |=> !aux_out_switch)
      else $error("switch on before por");
   chk_thr_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> aux_uv_threshold == $past(aux_uv_threshold_cfg))
      else $error("threshold not taken");
   chk_switch_cond: assert property (@(posedge sys_clk) disable iff (!resetn)
      !aux_switch_request |=> !aux_out_switch)
      else $error("switch on unrequested");
   chk_switch_main: assert property (@(posedge sys_clk) disable iff (!resetn)
      (aux_switch_need_main && !main_ok) |=> !aux_out_switch)
      else $error("switch on without main");
   chk_switch_on: assert property (@(posedge sys_clk) disable iff (!resetn)
      (aux_switch_request && por_m && main_ok) |=> aux_out_switch)
      else $error("switch not enabled");

   // reset output, and end-to-end latency through the three-stage filter
   sequence raw_uv_s;
      aux_uv_in [*5];
   endsequence
   sequence raw_mrst_s;
      (manual_reset_in ^ st_r.mpol) [*5];
   endsequence
   chk_uv_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      aux_uv |=> !reset_out_n)
      else $error("uv reset missing");
   chk_reset_release: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!aux_uv && !mrst_asserted(mrst_lvl, st_r.mpol)) |=> reset_out_n)
      else $error("reset output not released");
   chk_mrst_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      mrst_asserted(mrst_lvl, st_r.mpol) |=> !reset_out_n)
      else $error("manual reset missing");
   chk_mpol_take: assert property (@(posedge sys_clk) disable iff (!resetn)
      !st_r.cfg_taken |=> st_r.mpol == $past(mrst_active_low_cfg))
      else $error("polarity not captured");
   chk_mpol_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      st_r.cfg_taken |=> $stable(st_r.mpol))
      else $error("polarity changed after capture");
   chk_uv_latency: assert property (@(posedge sys_clk) disable iff (!resetn)
      raw_uv_s |=> !reset_out_n)
      else $error("uv input too slow");
   chk_mrst_latency: assert property (@(posedge sys_clk) disable iff (!resetn)
      raw_mrst_s |=> !reset_out_n)
      else $error("manual reset input too slow");
   chk_pulldown: assert property (@(posedge sys_clk) disable iff (!resetn)
      aux_out_pulldown != aux_out_switch)
      else $error("pulldown wrong");
endmodule

// file: supply_env_model.sv
`timescale 1ns/1ns
module supply_env_model (
   input wire logic main_on,
   input wire logic vbus_on,
   input wire logic aux_out_switch,
   input wire logic aux_sag,
   input wire logic press,
   input wire logic active_low,
   output logic main_good_in,
   output logic main_below_2v85_in,
   output logic vbus_good_in,
   output logic aux_uv_in,
   output logic manual_reset_in
);
   assign main_good_in = main_on;
   assign main_below_2v85_in = !main_on;
   assign vbus_good_in = vbus_on;
   // pulled-down output reads as undervoltage
   assign aux_uv_in = !aux_out_switch || aux_sag;
   assign manual_reset_in = press ^ active_low;
endmodule

// file: test_supply_select_reset_supervisor.sv
`timescale 1ns/1ns
`include "supply_defines.svh"
module test_supply_select_reset_supervisor;
   import supply_pkg::*;
   logic sys_clk = 0, resetn = 0, main_on = 1, vbus_on = 1, aux_sag = 0, press = 0, mrst_active_low_cfg = 0;
   logic por = 1, aux_switch_request = 0, need_main = 1;
   logic [3:0] aux_uv_threshold_cfg = 4'h0;
   logic main_good_in, main_below_2v85_in, vbus_good_in, aux_uv_in, manual_reset_in;
   logic sel_main_supply, sel_vbus_supply, hard_reset_req, dead_battery, main_domain_enable, vbus_domain_enable;
   logic internal_3v3_rail_enable, aux_out_switch, aux_out_pulldown, reset_out_n;
   logic [3:0] aux_uv_threshold;
   supply_src_type supply_src;
   int fails = 0, samples_checked = 0, hr_len = 0;
   initial forever #10 sys_clk = ~sys_clk;
   supply_env_model i_supply_env_model (.main_on, .vbus_on, .aux_out_switch, .aux_sag, .press,
      .active_low(mrst_active_low_cfg), .main_good_in, .main_below_2v85_in, .vbus_good_in, .aux_uv_in,
      .manual_reset_in);
   supply_select_reset_supervisor i_supply_select_reset_supervisor (.sys_clk, .resetn, .main_good_in,
      .main_below_2v85_in, .vbus_good_in, .por_main_good_in(por), .por_vbus_good_in(por),
      .por_rail_good_in(por), .aux_uv_in, .manual_reset_in, .mrst_active_low_cfg, .aux_switch_request,
      .aux_switch_need_main(need_main), .aux_uv_threshold_cfg, .supply_src, .sel_main_supply, .sel_vbus_supply,
      .hard_reset_req, .dead_battery, .main_domain_enable, .vbus_domain_enable, .internal_3v3_rail_enable,
      .aux_uv_threshold, .aux_out_switch, .aux_out_pulldown, .reset_out_n);
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      step(5);
      resetn = 1;
      step(8);
      chk("src", supply_src, src_main);
      chk("sel", {sel_main_supply, sel_vbus_supply}, 2'b10);
      chk("dead", dead_battery, 1'b0);
      chk("domains", {main_domain_enable, vbus_domain_enable, internal_3v3_rail_enable}, 3'b111);
      chk("switch", {aux_out_switch, aux_out_pulldown}, 2'b01);
      chk("reset_out", reset_out_n, 1'b0);
      main_on = 0;
      for (int i = 0; i < 20 && hard_reset_req !== 1'b1; i++) step(1);
      chk("hard_reset", hard_reset_req, 1'b1);
      if (hard_reset_req !== 1'b1) results();
      step(6);
      chk("src", supply_src, src_vbus);
      chk("sel", {sel_main_supply, sel_vbus_supply}, 2'b01);
      chk("dead", dead_battery, 1'b1);
      // six cycles of the pulse already seen
      hr_len = 6;
      for (int i = 0; i < 80 && hard_reset_req === 1'b1; i++) begin
         hr_len++;
         step(1);
      end
      chk("hard_reset_len", hr_len[7:0], 8'(`HARD_RESET_CYCLES + 1));
      main_on = 1;
      for (int i = 0; i < 8; i++) begin
         step(1);
         chk("hard_reset", hard_reset_req, 1'b0);
      end
      chk("src", supply_src, src_main);
      aux_switch_request = 1;
      step(8);
      chk("switch", {aux_out_switch, aux_out_pulldown}, 2'b10);
      chk("reset_out", reset_out_n, 1'b1);
      aux_sag = 1;
      step(8);
      chk("reset_out", reset_out_n, 1'b0);
      aux_sag = 0;
      press = 1;
      step(8);
      chk("reset_out", reset_out_n, 1'b0);
      press = 0;
      step(8);
      chk("reset_out", reset_out_n, 1'b1);
      main_on = 0;
      step(8);
      chk("switch", {aux_out_switch, aux_out_pulldown}, 2'b01);
      need_main = 0;
      step(2);
      chk("switch", {aux_out_switch, aux_out_pulldown}, 2'b10);
      need_main = 1;
      main_on = 1;
      aux_uv_threshold_cfg = 4'ha;
      por = 0;
      step(8);
      chk("threshold", aux_uv_threshold, 4'ha);
      chk("domains", {main_domain_enable, vbus_domain_enable, internal_3v3_rail_enable}, 3'b000);
      chk("src", supply_src, src_none);
      chk("switch", {aux_out_switch, aux_out_pulldown}, 2'b01);
      por = 1;
      resetn = 0;
      mrst_active_low_cfg = 1;
      step(5);
      chk("reset_out", reset_out_n, 1'b0);
      chk("switch", {aux_out_switch, aux_out_pulldown}, 2'b01);
      resetn = 1;
      step(12);
      chk("reset_out", reset_out_n, 1'b1);
      press = 1;
      step(8);
      chk("reset_out", reset_out_n, 1'b0);
      results();
   end
endmodule
